// File: core/dac_value_pkg.sv
// ***********************************************
// shared constants of the channel value bank
// ***********************************************
package dac_value_pkg;

   // ***********************************************
   // geometry
   // ***********************************************
   localparam int NUM_CH    = 16;
   localparam int CODE_W    = 16;
   localparam int TRIM_W    = 12;
   localparam int ADDR_W    = 9;
   localparam int NV_WORDS  = 48;
   localparam int NV_IDX_W  = 6;

   // ***********************************************
   // array base offsets, byte addresses, stride 2
   // ***********************************************
   localparam logic [8:0] IMM_BASE       = 9'h040;
   localparam logic [8:0] TRG_BASE       = 9'h060;
   localparam logic [8:0] OFS_TRIM_BASE  = 9'h080;
   localparam logic [8:0] GAIN_TRIM_BASE = 9'h0A0;
   localparam logic [8:0] VOFS_CAL_BASE  = 9'h100;
   localparam logic [8:0] VGAIN_CAL_BASE = 9'h120;
   localparam logic [8:0] IOFS_CAL_BASE  = 9'h140;

   // address fields: array select and channel select
   localparam int ARR_LSB = 5;
   localparam int CH_LSB  = 1;

   // ***********************************************
   // trim codes and reset values
   // ***********************************************
   localparam logic [11:0] OFS_TRIM_NOM   = 12'h300;
   localparam logic [11:0] GAIN_TRIM_NOM  = 12'h800;
   localparam logic [11:0] VOFS_CAL_NOM   = 12'h800;
   localparam logic [15:0] CODE_RST       = 16'h0000;
   localparam logic [11:0] OFS_TRIM_RST   = OFS_TRIM_NOM;
   localparam logic [11:0] GAIN_TRIM_RST  = GAIN_TRIM_NOM;

   // full scale of a channel: millivolts or microamps
   localparam int FS_VOLT_MV = 16000;
   localparam int FS_CURR_UA = 20000;

   // calibration copy groups inside the non-volatile index
   localparam logic [1:0] GRP_VOFS  = 2'h0;
   localparam logic [1:0] GRP_VGAIN = 2'h1;
   localparam logic [1:0] GRP_IOFS  = 2'h2;

   // power-on copy sequencer
   typedef enum logic [2:0] {
      CP_IDLE = 3'b001,
      CP_RUN  = 3'b010,
      CP_DONE = 3'b100
   } copy_state_t;

endpackage : dac_value_pkg

// File: core/nv_cal_store.sv
`timescale 1ns/1ns
// ***********************************************
// calibration constant store with power-on copy
// ***********************************************
module nv_cal_store
   import dac_value_pkg::*;
(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // write port
   input  wire logic                wr_en,
   input  wire logic [NV_IDX_W-1:0] wr_idx,
   input  wire logic [CODE_W-1:0]   wr_data,
   // copy stream
   output logic                     copy_vld,
   output logic [NV_IDX_W-1:0]      copy_idx,
   output logic [CODE_W-1:0]        copy_data,
   output logic                     copy_done
);

   // contents survive reset on purpose, as the flash does
   logic [CODE_W-1:0]   mem [0:NV_WORDS-1];
   copy_state_t         state_r;
   copy_state_t         state_nxt;
   logic [NV_IDX_W-1:0] idx_r;
   logic [NV_IDX_W-1:0] idx_nxt;
   wire                 last_w = (idx_r == NV_IDX_W'(NV_WORDS - 1));

   // store writes
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // walk every word once after reset
   always_comb begin
      state_nxt = state_r;
      idx_nxt   = idx_r;
      case (state_r)
         CP_IDLE: state_nxt = CP_RUN;
         CP_RUN: begin
            idx_nxt = idx_r + NV_IDX_W'(1);
            if (last_w) begin
               state_nxt = CP_DONE;
            end
         end
         CP_DONE: state_nxt = CP_DONE;
         default: state_nxt = CP_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r   <= CP_IDLE;
         idx_r     <= '0;
         copy_vld  <= 1'b0;
         copy_idx  <= '0;
         copy_data <= '0;
         copy_done <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         idx_r     <= idx_nxt;
         copy_vld  <= (state_r == CP_RUN);
         copy_idx  <= idx_r;
         copy_data <= mem[idx_r];
         copy_done <= (state_r == CP_RUN) && last_w;
      end
   end

endmodule : nv_cal_store

// File: core/dac_value_regs.sv
`timescale 1ns/1ns
// Functional notes
// - sixteen write-only immediate words, stride 2, drive the channel at once.
// - every output word is a signed two's complement code.
// - full scale is 16 volts in voltage mode, 20 milliamps in current mode.
// - sixteen triggered words are held until the next trigger event.
// - one trigger applies all pending channels in the same cycle.
// - offset trims use the low 12 bits, apply at once.
// - offset code 0 max positive, 300 hex zero, FFF max negative.
// - gain trims 12 bits at once; 0 minimum, 800 hex nominal, FFF maximum.
// - sixteen stored voltage offset constants, 12 bits, 800 hex is zero.
// - sixteen stored voltage gain constants, 12 bits, zero to all ones.
// - sixteen stored current offset constants accept written values.
// - stored constants are copied at power-on; only the copy is used.
// - an immediate write outputs at once and clears the pending flag.
// - a triggered write sets the pending flag; clear flags ignore triggers.
module dac_value_regs
   import dac_value_pkg::*;
(
   // clock and reset
   input  wire logic                           clock,
   input  wire logic                           sys_rst,
   // register write port
   input  wire logic                           reg_wr_stb,
   input  wire logic [ADDR_W-1:0]              reg_addr,
   input  wire logic [CODE_W-1:0]              reg_wdata,
   // trigger and channel modes from the card logic
   input  wire logic                           trig_evt,
   input  wire logic [NUM_CH-1:0]              chan_mode_volt,
   // channel outputs
   output logic [NUM_CH-1:0][CODE_W-1:0]       out_code_r,
   output logic [NUM_CH-1:0]                   out_neg_r,
   output logic [NUM_CH-1:0]                   unit_volt_r,
   output logic [NUM_CH-1:0]                   trigger_pending_flag_r,
   // trims and their decoded deltas
   output logic [NUM_CH-1:0][TRIM_W-1:0]       ofs_trim_r,
   output logic [NUM_CH-1:0][TRIM_W-1:0]       gain_trim_r,
   output logic [NUM_CH-1:0][TRIM_W:0]         ofs_delta_r,
   output logic [NUM_CH-1:0][TRIM_W:0]         gain_delta_r,
   // working copies of the calibration constants
   output logic [NUM_CH-1:0][TRIM_W-1:0]       vofs_work_r,
   output logic [NUM_CH-1:0][TRIM_W:0]         vofs_delta_r,
   output logic [NUM_CH-1:0][TRIM_W-1:0]       vgain_work_r,
   output logic [NUM_CH-1:0][CODE_W-1:0]       iofs_work_r,
   output logic                                cal_ready_r
);

   // ***********************************************
   // helpers
   // ***********************************************
   // even address inside a 32-byte array window
   function automatic logic in_array(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base);
      return (a[ADDR_W-1:ARR_LSB] == base[ADDR_W-1:ARR_LSB]) && !a[0];
   endfunction : in_array

   // signed distance of a 12-bit code from another, 13 bits
   function automatic logic [TRIM_W:0] trim_delta(input logic [TRIM_W-1:0] a,
                                                  input logic [TRIM_W-1:0] b);
      return {1'b0, a} - {1'b0, b};
   endfunction : trim_delta

   // ***********************************************
   // address decode
   // ***********************************************
   // odd or unmapped addresses fall through every hit and are dropped
   wire [3:0]  wr_ch      = reg_addr[CH_LSB+3:CH_LSB];
   wire        imm_hit    = reg_wr_stb && in_array(reg_addr, IMM_BASE);
   wire        trg_hit    = reg_wr_stb && in_array(reg_addr, TRG_BASE);
   wire        ofs_hit    = reg_wr_stb && in_array(reg_addr, OFS_TRIM_BASE);
   wire        gain_hit   = reg_wr_stb && in_array(reg_addr, GAIN_TRIM_BASE);
   wire        nv_hit     = reg_wr_stb && (in_array(reg_addr, VOFS_CAL_BASE)
                                        || in_array(reg_addr, VGAIN_CAL_BASE)
                                        || in_array(reg_addr, IOFS_CAL_BASE));
   wire [NV_IDX_W-1:0] nv_idx = {reg_addr[ARR_LSB+1:ARR_LSB], wr_ch};
   wire [NUM_CH-1:0]   ch_sel = NUM_CH'(1) << wr_ch;

   // trigger reaches only channels with a pending word
   wire [NUM_CH-1:0] apply_w = trigger_pending_flag_r & {NUM_CH{trig_evt}};

   // ***********************************************
   // per-channel next values
   // ***********************************************
   logic [NUM_CH-1:0][CODE_W-1:0] held_r;
   logic [NUM_CH-1:0][CODE_W-1:0] held_nxt;
   logic [NUM_CH-1:0][CODE_W-1:0] out_code_nxt;
   logic [NUM_CH-1:0]             pend_nxt;
   // word-wide copy of apply_w, read only by the checks
   logic [NUM_CH-1:0][CODE_W-1:0] apply_mask_w;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         // immediate write beats a trigger landing in the same cycle
         assign out_code_nxt[gi] = (imm_hit && ch_sel[gi]) ? reg_wdata
                                 : apply_w[gi]             ? held_r[gi]
                                 : out_code_r[gi];
         assign held_nxt[gi]     = (trg_hit && ch_sel[gi]) ? reg_wdata : held_r[gi];
         assign apply_mask_w[gi] = {CODE_W{apply_w[gi]}};
         // a fresh triggered write survives a trigger in its own cycle
         assign pend_nxt[gi]     = (trg_hit && ch_sel[gi]) ? 1'b1
                                 : (imm_hit && ch_sel[gi]) ? 1'b0
                                 : apply_w[gi]             ? 1'b0
                                 : trigger_pending_flag_r[gi];
      end
   endgenerate

   // ***********************************************
   // main output words
   // ***********************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         out_code_r             <= {NUM_CH{CODE_RST}};
         held_r                 <= {NUM_CH{CODE_RST}};
         trigger_pending_flag_r <= '0;
         out_neg_r              <= '0;
         unit_volt_r            <= '0;
      end else begin
         out_code_r             <= out_code_nxt;
         held_r                 <= held_nxt;
         trigger_pending_flag_r <= pend_nxt;
         for (int i = 0; i < NUM_CH; i++) begin
            out_neg_r[i] <= out_code_nxt[i][CODE_W-1];
         end
         // selects the 16 V or 20 mA full-scale range of each channel
         unit_volt_r            <= chan_mode_volt;
      end
   end

   // ***********************************************
   // trims, applied at once, upper four bits dropped
   // ***********************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ofs_trim_r   <= {NUM_CH{OFS_TRIM_RST}};
         gain_trim_r  <= {NUM_CH{GAIN_TRIM_RST}};
         ofs_delta_r  <= '0;
         gain_delta_r <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (ofs_hit && ch_sel[i]) begin
               ofs_trim_r[i]  <= reg_wdata[TRIM_W-1:0];
               ofs_delta_r[i] <= trim_delta(OFS_TRIM_NOM, reg_wdata[TRIM_W-1:0]);
            end
            if (gain_hit && ch_sel[i]) begin
               gain_trim_r[i]  <= reg_wdata[TRIM_W-1:0];
               gain_delta_r[i] <= trim_delta(reg_wdata[TRIM_W-1:0], GAIN_TRIM_NOM);
            end
         end
      end
   end

   // ***********************************************
   // calibration store and power-on working copy
   // ***********************************************
   logic                copy_vld;
   logic [NV_IDX_W-1:0] copy_idx;
   logic [CODE_W-1:0]   copy_data;
   logic                copy_done;

   // stored words change only here; the working copy is not refreshed
   nv_cal_store u_store (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .wr_en     (nv_hit),
      .wr_idx    (nv_idx),
      .wr_data   (reg_wdata),
      .copy_vld  (copy_vld),
      .copy_idx  (copy_idx),
      .copy_data (copy_data),
      .copy_done (copy_done)
   );

   wire [1:0] cp_grp = copy_idx[NV_IDX_W-1:4];
   wire [3:0] cp_ch  = copy_idx[3:0];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vofs_work_r  <= {NUM_CH{VOFS_CAL_NOM}};
         vofs_delta_r <= '0;
         vgain_work_r <= '0;
         iofs_work_r  <= '0;
         cal_ready_r  <= 1'b0;
      end else begin
         if (copy_vld && cp_grp == GRP_VOFS) begin
            vofs_work_r[cp_ch]  <= copy_data[TRIM_W-1:0];
            vofs_delta_r[cp_ch] <= trim_delta(VOFS_CAL_NOM, copy_data[TRIM_W-1:0]);
         end
         if (copy_vld && cp_grp == GRP_VGAIN) begin
            vgain_work_r[cp_ch] <= copy_data[TRIM_W-1:0];
         end
         if (copy_vld && cp_grp == GRP_IOFS) begin
            iofs_work_r[cp_ch]  <= copy_data;
         end
         if (copy_done) begin
            cal_ready_r <= 1'b1;
         end
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_trg_write;
      trg_hit && !trig_evt;
   endsequence
   sequence s_fire_alone;
      trig_evt && !reg_wr_stb;
   endsequence

   a_imm_drives_out:  assert property (imm_hit |=> out_code_r[$past(wr_ch)] == $past(reg_wdata))
      else $error("immediate word not on output");
   a_imm_clears_pend: assert property (imm_hit && !trg_hit |=> !trigger_pending_flag_r[$past(wr_ch)])
      else $error("immediate write left channel pending");
   a_trg_sets_pend:   assert property (trg_hit |=> trigger_pending_flag_r[$past(wr_ch)])
      else $error("triggered write did not set pending");
   a_trg_holds_out:   assert property (s_trg_write ##1 (!trig_evt && !imm_hit) |=> $stable(out_code_r))
      else $error("output moved without trigger");
   // pending channels take their held word, the others keep theirs
   a_trigger_applies: assert property (s_fire_alone
      |=> ((out_code_r ^ $past(held_r)) & $past(apply_mask_w)) == '0
      && ((out_code_r ^ $past(out_code_r)) & ~$past(apply_mask_w)) == '0
      && (trigger_pending_flag_r & $past(apply_w)) == '0)
      else $error("trigger did not apply pending words");
   a_idle_ignores:    assert property (trig_evt && trigger_pending_flag_r == '0
                                       && !reg_wr_stb |=> $stable(out_code_r))
      else $error("trigger changed a channel with no pending word");
   a_ofs_decode:      assert property (ofs_hit && reg_wdata[TRIM_W-1:0] == 12'h300
                                       |=> ofs_delta_r[$past(wr_ch)] == 13'h0000)
      else $error("nominal offset code not zero");
   a_gain_trim_now:   assert property (gain_hit |=> gain_trim_r[$past(wr_ch)]
                                       == $past(reg_wdata[TRIM_W-1:0]))
      else $error("gain trim not applied at once");
   a_ofs_trim_now:    assert property (ofs_hit |=> ofs_trim_r[$past(wr_ch)]
                                       == $past(reg_wdata[TRIM_W-1:0]))
      else $error("offset trim not applied at once");
   a_neg_sign:        assert property (imm_hit |=> out_neg_r[$past(wr_ch)]
                                       == $past(reg_wdata[CODE_W-1]))
      else $error("sign flag disagrees with code");
   // once the copy is done nothing may touch the working words
   a_cal_frozen:      assert property (cal_ready_r |=> $stable(vofs_work_r)
                                       && $stable(vgain_work_r) && $stable(iofs_work_r))
      else $error("working copy changed after power-on");
   a_pend_then_apply: assert property (s_trg_write ##1 (!reg_wr_stb && !trig_evt)
                                       ##1 s_fire_alone |=> out_code_r[$past(wr_ch, 3)]
                                       == $past(reg_wdata, 3))
      else $error("held word not applied by the next trigger");

endmodule : dac_value_regs

// File: verif/bus_ctl_model.sv
`timescale 1ns/1ns
// ***********************************************
// backplane controller: register writes
// ***********************************************
module bus_ctl_model
   import dac_value_pkg::*;
(
   // clock
   input  wire logic          clock,
   // write port toward the bank
   output logic               reg_wr_stb,
   output logic [ADDR_W-1:0]  reg_addr,
   output logic [CODE_W-1:0]  reg_wdata
);
   // idle bus until the first write
   initial begin
      reg_wr_stb = 1'b0;
      reg_addr   = '0;
      reg_wdata  = '0;
   end

   // one write, launched and released on falling edges;
   // cal words go in plainly, at most twice each per run, since the
   // bank has no programming sequence and wear is a flash cost
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [CODE_W-1:0] d);
      @(negedge clock);
      reg_wr_stb = 1'b1;
      reg_addr   = a;
      reg_wdata  = d;
      @(negedge clock);
      reg_wr_stb = 1'b0;
      // released lines show inverted leftovers, never the old word
      reg_addr   = ~a;
      reg_wdata  = ~d;
   endtask : wr
endmodule : bus_ctl_model

// File: verif/multichannel_dac_value_registers_test.sv
`timescale 1ns/1ns
module multichannel_dac_value_registers_test import dac_value_pkg::*;;
   logic clock, sys_rst, trig_evt, ready, stb;
   logic [NUM_CH-1:0] mode_volt, neg, unit, pend;
   logic [ADDR_W-1:0] addr;
   logic [NUM_CH-1:0][CODE_W-1:0] code, iofs;
   logic [CODE_W-1:0] wdata;
   logic [NUM_CH-1:0][TRIM_W-1:0] otrim, gtrim, vofs, vgain;
   logic [NUM_CH-1:0][TRIM_W:0] odel, gdel, vdel;
   logic [TRIM_W-1:0] tc [3];
   logic [TRIM_W:0] td [3];
   int n_fail, n_compared, cyc;

   // ***********************************************
   // clock, controller and bank
   // ***********************************************
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   bus_ctl_model ctl (.clock(clock), .reg_wr_stb(stb), .reg_addr(addr), .reg_wdata(wdata));
   dac_value_regs DUT (.clock(clock), .sys_rst(sys_rst), .reg_wr_stb(stb),
      .reg_addr(addr), .reg_wdata(wdata), .trig_evt(trig_evt),
      .chan_mode_volt(mode_volt), .out_code_r(code), .out_neg_r(neg),
      .unit_volt_r(unit), .trigger_pending_flag_r(pend), .ofs_trim_r(otrim),
      .gain_trim_r(gtrim), .ofs_delta_r(odel), .gain_delta_r(gdel),
      .vofs_work_r(vofs), .vofs_delta_r(vdel), .vgain_work_r(vgain),
      .iofs_work_r(iofs), .cal_ready_r(ready));

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // mixed-sign pattern, distinct per channel
   function automatic logic [15:0] imm_val(input int i);
      return 16'h8001 + 16'(i) * 16'h1111;
   endfunction : imm_val
   task automatic pulse_trig();
      @(negedge clock);
      trig_evt = 1'b1;
      @(negedge clock);
      trig_evt = 1'b0;
   endtask : pulse_trig
   task automatic test_done();
      $display("counts: %0d compared, %0d mismatches", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // hang guard, far above the few hundred cycles needed
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         $display("mismatch at %0t: run too long", $time);
         test_done();
      end
   end

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      sys_rst = 1'b1;
      trig_evt = 1'b0;
      mode_volt = '0;
      repeat (10) @(negedge clock);
      sys_rst = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         chk(code[i], CODE_RST, "reset code");
         chk(16'(pend[i]), 16'h0, "reset flag");
         chk(16'(otrim[i]), 16'(OFS_TRIM_RST), "reset ofs trim");
         chk(16'(gtrim[i]), 16'(GAIN_TRIM_RST), "reset gain trim");
      end
      $display("test reset done");
      // immediate words, all channels, then all held
      for (int i = 0; i < NUM_CH; i++) begin
         ctl.wr(IMM_BASE + 9'(2 * i), imm_val(i));
         chk(code[i], imm_val(i), "imm code");
         chk(16'(neg[i]), 16'(imm_val(i) >> 15), "sign");
      end
      ctl.wr(IMM_BASE + 9'h001, 16'h1234);
      ctl.wr(9'h0C0, 16'h1234);
      ctl.wr(9'h1C0, 16'h1234);
      for (int i = 0; i < NUM_CH; i++) chk(code[i], imm_val(i), "held code");
      $display("test immediate done");
      // two triggered words applied together by one trigger
      ctl.wr(TRG_BASE + 9'h006, 16'h7FFF);
      ctl.wr(TRG_BASE + 9'h01E, 16'h8000);
      chk(16'(pend), 16'h8008, "flags set");
      chk(code[3], imm_val(3), "withheld");
      pulse_trig();
      chk(code[3], 16'h7FFF, "trig ch3");
      chk(code[15], 16'h8000, "trig ch15");
      chk(16'(pend), 16'h0, "flags cleared");
      pulse_trig();
      chk(code[3], 16'h7FFF, "idle trig");
      // immediate write overrides a pending word
      ctl.wr(TRG_BASE + 9'h00A, 16'h1111);
      ctl.wr(IMM_BASE + 9'h00A, 16'h2222);
      chk(code[5], 16'h2222, "imm wins");
      chk(16'(pend[5]), 16'h0, "flag off");
      pulse_trig();
      chk(code[5], 16'h2222, "no stale apply");
      // trigger and triggered write in one cycle: old word out, new one pending
      ctl.wr(TRG_BASE + 9'h00A, 16'h3333);
      fork
         ctl.wr(TRG_BASE + 9'h00A, 16'h4444);
         pulse_trig();
      join
      chk(code[5], 16'h3333, "old word applied");
      chk(16'(pend[5]), 16'h1, "set wins");
      pulse_trig();
      chk(code[5], 16'h4444, "new word applied");
      chk(16'(pend), 16'h0, "all flags clear");
      $display("test trigger done");
      // voltage-mode trims for channels 0..2, ends of the code ranges
      @(negedge clock);
      mode_volt = 16'h00FF;
      @(negedge clock);
      chk(16'(unit), 16'h00FF, "range");
      // expected deltas: largest positive, zero, largest negative
      tc = '{12'h000, 12'h300, 12'hFFF};
      td = '{13'h0300, 13'h0000, 13'h1301};
      for (int k = 0; k < 3; k++) begin
         ctl.wr(OFS_TRIM_BASE + 9'(2 * k), {4'hF, tc[k]});
         chk(16'(otrim[k]), 16'(tc[k]), "ofs trim");
         chk(16'(odel[k]), 16'(td[k]), "ofs");
      end
      // expected deltas: minimum, nominal, maximum gain
      tc = '{12'h000, 12'h800, 12'hFFF};
      td = '{13'h1800, 13'h0000, 13'h07FF};
      for (int k = 0; k < 3; k++) begin
         ctl.wr(GAIN_TRIM_BASE + 9'(2 * k), {4'hA, tc[k]});
         chk(16'(gtrim[k]), 16'(tc[k]), "gain trim");
         chk(16'(gdel[k]), 16'(td[k]), "gain");
      end
      $display("test trims done");
      // stored constants reach the working copy only through a reset
      for (int i = 0; i < NUM_CH; i++) begin
         ctl.wr(VOFS_CAL_BASE + 9'(2 * i), 16'hF800 + 16'(i));
         ctl.wr(VGAIN_CAL_BASE + 9'(2 * i), 16'hA000 + 16'(i * 16));
         ctl.wr(IOFS_CAL_BASE + 9'(2 * i), 16'hC000 + 16'(i));
      end
      @(negedge clock);
      sys_rst = 1'b1;
      repeat (2) @(negedge clock);
      chk(16'(ready), 16'h0, "ready low");
      sys_rst = 1'b0;
      for (int w = 0; w < 200 && ready !== 1'b1; w++) @(negedge clock);
      chk(16'(ready), 16'h1, "copy finished");
      for (int i = 0; i < NUM_CH; i++) begin
         chk(16'(vofs[i]), 16'h0800 + 16'(i), "vofs copy");
         chk(16'(vdel[i]), {3'h0, 13'(-i)}, "vofs delta");
         chk(16'(vgain[i]), 16'(i * 16), "vgain copy");
         chk(iofs[i], 16'hC000 + 16'(i), "iofs copy");
      end
      // a rewrite after power-on reaches only the store
      ctl.wr(VOFS_CAL_BASE + 9'h004, 16'h0123);
      ctl.wr(IOFS_CAL_BASE + 9'h004, 16'h0456);
      chk(16'(vofs[2]), 16'h0802, "copy untouched");
      chk(iofs[2], 16'hC002, "iofs untouched");
      $display("test calibration done");
      test_done();
   end
endmodule : multichannel_dac_value_registers_test
